// ==== pqim_params.svh ====
`ifndef PQIM_PARAMS_SVH
`define PQIM_PARAMS_SVH

// Register byte offsets on the bus
`define PQIM_OFF_STATUS 8'h00
`define PQIM_OFF_MASK 8'h04
`define PQIM_OFF_PHASE 8'h08
`define PQIM_OFF_THRESH 8'h0C

// Event bit positions in status and mask
`define PQIM_B_TOT_NL 0
`define PQIM_B_FUN_NL 1
`define PQIM_B_APP_NL 2
`define PQIM_B_ZXTO_V 3
`define PQIM_B_ZXTO_I 6
`define PQIM_B_ZX_V 9
`define PQIM_B_ZX_I 12
`define PQIM_B_RESET_COMPLETE_PLACEHOLDER 15
`define PQIM_B_DIP 16
`define PQIM_B_OI 17
`define PQIM_B_OV 18
`define PQIM_B_SEQ 19
`define PQIM_B_MISM 20
`define PQIM_B_PKI 23
`define PQIM_B_PKV 24

// Phase status field positions
`define PQIM_P_OI 3
`define PQIM_P_OV 9
`define PQIM_P_DIP 12

// Writable bits and reset values
`define PQIM_MASK_WBITS 32'h019F_FFFF
`define PQIM_MASK_RST 32'h0000_0000
`define PQIM_THRESH_RST 24'h00_0000
`define PQIM_SUM_W 24
`define PQIM_THR_W 24

`endif

// ==== pqim_pkg.sv ====
`default_nettype none

package pqim_pkg;

`include "pqim_params.svh"

    // Phase order checker states
    typedef enum logic [0:0] {
        PQIM_SEQ_IDLE,
        PQIM_SEQ_WAIT
    } pqim_seq_t;

    // Bus slave state
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } pqim_wb_t;

    // Core register state
    typedef struct packed {
        logic [31:0] mask;
        logic [`PQIM_THR_W-1:0] thresh;
        logic [2:0] nl_tot;
        logic [2:0] nl_fun;
        logic [2:0] nl_app;
        pqim_seq_t seq;
        logic boot;
    } pqim_core_t;

endpackage

`default_nettype wire

// ==== pqim_reg_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// Decoded register access between bus slave and core
interface pqim_reg_if;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] sel;
    logic [31:0] rdata;
    modport bus (output wr, output addr, output wdata, output sel,
                 input rdata);
    modport regs (input wr, input addr, input wdata, input sel,
                  output rdata);
endinterface

`default_nettype wire

// ==== pqim_sticky.sv ====
`timescale 1ns/1ps
`default_nettype none

module pqim_sticky #(
    parameter int W = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    output logic [W-1:0] flags_o
);

    typedef struct packed {
        logic [W-1:0] flags;
    } pqim_sticky_t;

    pqim_sticky_t q;
    pqim_sticky_t d;

    // Set wins over a same-cycle clear so no event is lost
    always_comb begin
        d = q;
        d.flags = (q.flags & ~clr_i) | set_i;
    end

    // Flag register, cleared by the synchronous reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign flags_o = q.flags;

endmodule

`default_nettype wire

// ==== pqim_wb_slave.sv ====
`timescale 1ns/1ps
`default_nettype none

module pqim_wb_slave
    import pqim_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    pqim_reg_if.bus regs
);

    pqim_wb_t q;
    pqim_wb_t d;
    logic req;

    assign req = wb_cyc_i && wb_stb_i;

    // One wait state; ack drops the cycle after it is given
    always_comb begin
        d = q;
        d.ack = req && !q.ack;
        if (req && !q.ack) begin
            d.dat = wb_we_i ? 32'h0000_0000 : regs.rdata;
        end
    end

    // Slave state register, idle after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Write lands on the edge where the master sees ack
    assign regs.wr = req && wb_we_i && q.ack;
    assign regs.addr = wb_adr_i;
    assign regs.wdata = wb_dat_i;
    assign regs.sel = wb_sel_i;
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.dat;

endmodule

`default_nettype wire

// ==== pqim_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pqim_params.svh"

// Operation
// R1 - Bit 0 enables total power no-load entry
// R2 - Bit 1 enables fundamental power no-load entry
// R3 - Bit 2 enables apparent power no-load entry
// R4 - Bits 3-5 enable voltage crossing timeouts
// R5 - Bits 6-8 enable current crossing timeouts
// R6 - Bits 9-11 enable voltage crossing detection
// R7 - Bits 12-14 enable current crossing detection
// R8 - Bit 15 stored but reset-done always enabled
// R9 - Bit 16 enables dip, phase in 14-12
// R10 - Bit 17 enables overcurrent, phase in 5-3
// R11 - Bit 18 enables over-level, phase in 11-9
// R12 - Bit 19 enables phase order A-C-B error
// R13 - Bit 20 enables current sum mismatch
// R14 - Bit 23 enables current peak period end
// R15 - Bit 24 enables voltage peak period end
// R16 - Reserved bits reset zero, control nothing
// R17 - Request high while enabled flag is set

module pqim_top
    import pqim_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Per-phase no-load levels, bit 0 is phase A
    input wire logic [2:0] total_noload_i,
    input wire logic [2:0] fundamental_noload_i,
    input wire logic [2:0] apparent_noload_i,
    // Missed crossing pulses, bit 0 is phase A
    input wire logic [2:0] volt_timeout_i,
    input wire logic [2:0] curr_timeout_i,
    // Rising crossing pulses, bit 0 is phase A
    input wire logic [2:0] volt_crossing_i,
    input wire logic [2:0] curr_crossing_i,
    // Per-phase level event pulses
    input wire logic [2:0] dip_i,
    input wire logic [2:0] curr_excess_i,
    input wire logic [2:0] volt_excess_i,
    // Current sum check samples
    input wire logic sum_valid_i,
    input wire logic [`PQIM_SUM_W-1:0] phase_current_sum_i,
    input wire logic [`PQIM_SUM_W-1:0] neutral_current_value_i,
    // Peak detection period ends
    input wire logic curr_peak_end_i,
    input wire logic volt_peak_end_i,
    // Interrupt request, active high level
    output logic irq_o,
    output logic [31:0] event_interrupt_enable_group_b_o
);

    localparam int SW = `PQIM_SUM_W;
    localparam int TW = `PQIM_THR_W;

    pqim_reg_if regs ();

    pqim_core_t q;
    pqim_core_t d;

    logic [31:0] status;
    logic [31:0] status_set;
    logic [31:0] status_clr;
    logic [15:0] phase_status;
    logic [15:0] phase_set;
    logic [15:0] phase_clr;
    logic [31:0] lanes;
    logic [31:0] enables;
    logic wr_status;
    logic wr_mask;
    logic wr_phase;
    logic wr_thresh;
    logic seq_error;
    logic mismatch;
    logic [SW:0] sum_diff;
    // Mask fields by name, so each gate below reads as its event
    logic total_noload_enable;
    logic fundamental_noload_enable;
    logic apparent_noload_enable;
    logic volt_a_crossing_timeout_enable;
    logic volt_b_crossing_timeout_enable;
    logic volt_c_crossing_timeout_enable;
    logic curr_a_crossing_timeout_enable;
    logic curr_b_crossing_timeout_enable;
    logic curr_c_crossing_timeout_enable;
    logic volt_a_crossing_enable;
    logic volt_b_crossing_enable;
    logic volt_c_crossing_enable;
    logic curr_a_crossing_enable;
    logic curr_b_crossing_enable;
    logic curr_c_crossing_enable;
    logic voltage_dip_enable;
    logic current_excess_enable;
    logic voltage_excess_enable;
    logic phase_order_error_enable;
    logic current_sum_mismatch_enable;
    logic curr_peak_end_enable;
    logic volt_peak_end_enable;

    // Byte lanes of a write as a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // Magnitude of the signed difference of two samples
    function automatic logic [SW:0] abs_diff(
        input logic [SW-1:0] a,
        input logic [SW-1:0] b
    );
        logic [SW:0] t;
        t = {a[SW-1], a} - {b[SW-1], b};
        abs_diff = t[SW] ? (~t + {{SW{1'b0}}, 1'b1}) : t;
    endfunction

    // Bus slave front end
    pqim_wb_slave u_wb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .regs(regs.bus)
    );

    // Address decode of the committed write
    assign lanes = lane_mask(regs.sel);
    assign wr_status = regs.wr && (regs.addr == `PQIM_OFF_STATUS);
    assign wr_mask = regs.wr && (regs.addr == `PQIM_OFF_MASK);
    assign wr_phase = regs.wr && (regs.addr == `PQIM_OFF_PHASE);
    assign wr_thresh = regs.wr && (regs.addr == `PQIM_OFF_THRESH);

    // Mismatch compares on every valid sample pair
    assign sum_diff = abs_diff(phase_current_sum_i,
                               neutral_current_value_i);
    assign mismatch = sum_valid_i &&
                      (sum_diff > {1'b0, q.thresh}); // R13

    // Phase order: after A rises, C rising before B is an error
    assign seq_error = (q.seq == PQIM_SEQ_WAIT) &&
                       volt_crossing_i[2] &&
                       !volt_crossing_i[1]; // R12

    // Event sources into the sticky status bits
    always_comb begin
        status_set = 32'h0000_0000;
        // Entry only: a phase that stays unloaded fires once
        status_set[`PQIM_B_TOT_NL] =
            |(total_noload_i & ~q.nl_tot); // R1
        status_set[`PQIM_B_FUN_NL] =
            |(fundamental_noload_i & ~q.nl_fun); // R2
        status_set[`PQIM_B_APP_NL] =
            |(apparent_noload_i & ~q.nl_app); // R3
        status_set[`PQIM_B_ZXTO_V +: 3] = volt_timeout_i; // R4
        status_set[`PQIM_B_ZXTO_I +: 3] = curr_timeout_i; // R5
        status_set[`PQIM_B_ZX_V +: 3] = volt_crossing_i; // R6
        status_set[`PQIM_B_ZX_I +: 3] = curr_crossing_i; // R7
        status_set[`PQIM_B_RESET_COMPLETE_PLACEHOLDER] = q.boot; // R8
        status_set[`PQIM_B_DIP] = |dip_i; // R9
        status_set[`PQIM_B_OI] = |curr_excess_i; // R10
        status_set[`PQIM_B_OV] = |volt_excess_i; // R11
        status_set[`PQIM_B_SEQ] = seq_error; // R12
        status_set[`PQIM_B_MISM] = mismatch; // R13
        status_set[`PQIM_B_PKI] = curr_peak_end_i; // R14
        status_set[`PQIM_B_PKV] = volt_peak_end_i; // R15
    end

    // Software clears by writing ones
    assign status_clr = wr_status ? (regs.wdata & lanes) : 32'h0000_0000;

    pqim_sticky #(
        .W(32)
    ) u_status (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(status_set),
        .clr_i(status_clr),
        .flags_o(status)
    );

    // Which phase caused a level event
    always_comb begin
        phase_set = 16'h0000;
        phase_set[`PQIM_P_OI +: 3] = curr_excess_i; // R10
        phase_set[`PQIM_P_OV +: 3] = volt_excess_i; // R11
        phase_set[`PQIM_P_DIP +: 3] = dip_i; // R9
    end

    // Always-zero phase bits can never be set, so clear is harmless
    assign phase_clr = wr_phase ? (regs.wdata[15:0] & lanes[15:0])
                                : 16'h0000;

    pqim_sticky #(
        .W(16)
    ) u_phase (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(phase_set),
        .clr_i(phase_clr),
        .flags_o(phase_status)
    );

    // Core state: mask, threshold, no-load history, order checker
    always_comb begin
        d = q;
        d.boot = 1'b0;
        d.nl_tot = total_noload_i;
        d.nl_fun = fundamental_noload_i;
        d.nl_app = apparent_noload_i;
        if (wr_mask) begin
            // Reserved bits are never stored, so they read zero
            d.mask = (q.mask & ~lanes) |
                     (regs.wdata & lanes & `PQIM_MASK_WBITS); // R16
        end
        if (wr_thresh) begin
            d.thresh = (q.thresh & ~lanes[TW-1:0]) |
                       (regs.wdata[TW-1:0] & lanes[TW-1:0]);
        end
        // A fresh A crossing restarts the wait for the next phase
        case (q.seq)
            PQIM_SEQ_IDLE: begin
                if (volt_crossing_i[0]) begin
                    d.seq = PQIM_SEQ_WAIT;
                end
            end
            PQIM_SEQ_WAIT: begin
                if (volt_crossing_i[1] || volt_crossing_i[2]) begin
                    d.seq = volt_crossing_i[0] ? PQIM_SEQ_WAIT
                                               : PQIM_SEQ_IDLE; // R12
                end
            end
            default: begin
                d.seq = PQIM_SEQ_IDLE;
            end
        endcase
    end

    // Core state register with synchronous reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q.mask <= `PQIM_MASK_RST; // R16
            q.thresh <= `PQIM_THRESH_RST;
            q.nl_tot <= 3'h0;
            q.nl_fun <= 3'h0;
            q.nl_app <= 3'h0;
            q.seq <= PQIM_SEQ_IDLE;
            q.boot <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Read mux; unmapped offsets answer zero
    always_comb begin
        case (regs.addr)
            `PQIM_OFF_STATUS: begin
                regs.rdata = status;
            end
            `PQIM_OFF_MASK: begin
                regs.rdata = q.mask;
            end
            `PQIM_OFF_PHASE: begin
                regs.rdata = {16'h0000, phase_status};
            end
            `PQIM_OFF_THRESH: begin
                regs.rdata = {{(32 - TW){1'b0}}, q.thresh};
            end
            default: begin
                regs.rdata = 32'h0000_0000;
            end
        endcase
    end

    // Bit 15 and the reserved bits get no field: they must gate nothing
    assign total_noload_enable = q.mask[`PQIM_B_TOT_NL];
    assign fundamental_noload_enable = q.mask[`PQIM_B_FUN_NL];
    assign apparent_noload_enable = q.mask[`PQIM_B_APP_NL];
    assign volt_a_crossing_timeout_enable = q.mask[`PQIM_B_ZXTO_V];
    assign volt_b_crossing_timeout_enable = q.mask[`PQIM_B_ZXTO_V + 1];
    assign volt_c_crossing_timeout_enable = q.mask[`PQIM_B_ZXTO_V + 2];
    assign curr_a_crossing_timeout_enable = q.mask[`PQIM_B_ZXTO_I];
    assign curr_b_crossing_timeout_enable = q.mask[`PQIM_B_ZXTO_I + 1];
    assign curr_c_crossing_timeout_enable = q.mask[`PQIM_B_ZXTO_I + 2];
    assign volt_a_crossing_enable = q.mask[`PQIM_B_ZX_V];
    assign volt_b_crossing_enable = q.mask[`PQIM_B_ZX_V + 1];
    assign volt_c_crossing_enable = q.mask[`PQIM_B_ZX_V + 2];
    assign curr_a_crossing_enable = q.mask[`PQIM_B_ZX_I];
    assign curr_b_crossing_enable = q.mask[`PQIM_B_ZX_I + 1];
    assign curr_c_crossing_enable = q.mask[`PQIM_B_ZX_I + 2];
    assign voltage_dip_enable = q.mask[`PQIM_B_DIP];
    assign current_excess_enable = q.mask[`PQIM_B_OI];
    assign voltage_excess_enable = q.mask[`PQIM_B_OV];
    assign phase_order_error_enable = q.mask[`PQIM_B_SEQ];
    assign current_sum_mismatch_enable = q.mask[`PQIM_B_MISM];
    assign curr_peak_end_enable = q.mask[`PQIM_B_PKI];
    assign volt_peak_end_enable = q.mask[`PQIM_B_PKV];

    // Reset-done cannot be masked; stored bit 15 is ignored here
    always_comb begin
        // Positions with no field except bit 15 stay zero whatever software stores
        enables = 32'h0000_0000; // R16
        enables[`PQIM_B_TOT_NL] = total_noload_enable; // R1
        enables[`PQIM_B_FUN_NL] = fundamental_noload_enable; // R2
        enables[`PQIM_B_APP_NL] = apparent_noload_enable; // R3
        // Missed crossings, phases A to C
        enables[`PQIM_B_ZXTO_V] = volt_a_crossing_timeout_enable; // R4
        enables[`PQIM_B_ZXTO_V + 1] = volt_b_crossing_timeout_enable; // R4
        enables[`PQIM_B_ZXTO_V + 2] = volt_c_crossing_timeout_enable; // R4
        enables[`PQIM_B_ZXTO_I] = curr_a_crossing_timeout_enable; // R5
        enables[`PQIM_B_ZXTO_I + 1] = curr_b_crossing_timeout_enable; // R5
        enables[`PQIM_B_ZXTO_I + 2] = curr_c_crossing_timeout_enable; // R5
        // Detected crossings, phases A to C
        enables[`PQIM_B_ZX_V] = volt_a_crossing_enable; // R6
        enables[`PQIM_B_ZX_V + 1] = volt_b_crossing_enable; // R6
        enables[`PQIM_B_ZX_V + 2] = volt_c_crossing_enable; // R6
        enables[`PQIM_B_ZX_I] = curr_a_crossing_enable; // R7
        enables[`PQIM_B_ZX_I + 1] = curr_b_crossing_enable; // R7
        enables[`PQIM_B_ZX_I + 2] = curr_c_crossing_enable; // R7
        enables[`PQIM_B_RESET_COMPLETE_PLACEHOLDER] = 1'b1; // R8
        // Level events, order, sum and peak period ends
        enables[`PQIM_B_DIP] = voltage_dip_enable; // R9
        enables[`PQIM_B_OI] = current_excess_enable; // R10
        enables[`PQIM_B_OV] = voltage_excess_enable; // R11
        enables[`PQIM_B_SEQ] = phase_order_error_enable; // R12
        enables[`PQIM_B_MISM] = current_sum_mismatch_enable; // R13
        enables[`PQIM_B_PKI] = curr_peak_end_enable; // R14
        enables[`PQIM_B_PKV] = volt_peak_end_enable; // R15
    end

    // Level request, drops as soon as the last enabled flag clears
    assign irq_o = |(status & enables); // R17
    assign event_interrupt_enable_group_b_o = q.mask;

endmodule

`default_nettype wire

// ==== pqim_top_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pqim_params.svh"

module pqim_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic irq_o,
    input wire logic [31:0] event_interrupt_enable_group_b_o,
    input wire logic [2:0] dip_i,
    input wire logic curr_peak_end_i,
    input wire logic volt_peak_end_i
);
    wire logic [31:0] m;
    // Short alias keeps the properties readable
    assign m = event_interrupt_enable_group_b_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Request present and not yet answered
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // Full-word mask write completing
    sequence s_mask_wr;
        wb_ack_o && wb_we_i && wb_sel_i == 4'hF &&
            wb_adr_i == `PQIM_OFF_MASK;
    endsequence
    a_ack_wait: assert property (s_take |=> wb_ack_o)
        else $error("ack not one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_mask_store: assert property (s_mask_wr |=>
        m == ($past(wb_dat_i) & `PQIM_MASK_WBITS))
        else $error("mask not stored as written");
    a_resv_zero: assert property ((m & ~`PQIM_MASK_WBITS) == 32'h0)
        else $error("reserved mask bit set");
    a_mask_read: assert property (wb_ack_o && !wb_we_i &&
        wb_adr_i == `PQIM_OFF_MASK |-> wb_dat_o == m)
        else $error("mask read differs");
    a_write_zero: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 0)
        else $error("read data not zero on write");
    a_boot_irq: assert property ($fell(rst_i) |-> ##[1:2] irq_o)
        else $error("no reset-done request");
    a_dip_irq: assert property (dip_i != 3'h0 && m[16] |=> irq_o)
        else $error("enabled dip gave no request");
    a_peak_irq: assert property ((curr_peak_end_i && m[23]) ||
        (volt_peak_end_i && m[24]) |=> irq_o)
        else $error("enabled peak end gave no request");
endmodule

`default_nettype wire

// ==== pqim_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pqim_params.svh"

module pqim_top_test;
    typedef struct packed {
        logic [3:0] g;
        logic [1:0] p;
        logic e;
    } pqim_row_t;
    // Event group, phase, enable; last row is a masked event
    localparam pqim_row_t ROWS [21] = '{'{0,0,1}, '{1,1,1}, '{2,2,1},
        '{3,0,1}, '{3,1,1}, '{3,2,1}, '{4,0,1}, '{4,1,1}, '{4,2,1},
        '{5,0,1}, '{5,1,1}, '{5,2,1}, '{6,0,1}, '{6,1,1}, '{6,2,1},
        '{7,1,1}, '{8,2,1}, '{9,0,1}, '{10,0,1}, '{11,0,1}, '{7,0,0}};
    logic clk_i = 0;
    logic rst_i = 1;
    logic cyc = 0, stb = 0, we = 0, sv = 0, ack, irq;
    logic [7:0] adr = 0;
    logic [31:0] wdat = 0, rdat, mask_o, q;
    logic [2:0] ev [12];
    logic [23:0] ps = 0, nv = 0;
    int err_total = 0, num_checks = 0, sb;
    always #20 clk_i = ~clk_i;
    pqim_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .total_noload_i(ev[0]), .fundamental_noload_i(ev[1]),
        .apparent_noload_i(ev[2]), .volt_timeout_i(ev[3]),
        .curr_timeout_i(ev[4]), .volt_crossing_i(ev[5]),
        .curr_crossing_i(ev[6]), .dip_i(ev[7]), .curr_excess_i(ev[8]),
        .volt_excess_i(ev[9]), .sum_valid_i(sv),
        .phase_current_sum_i(ps), .neutral_current_value_i(nv),
        .curr_peak_end_i(ev[10][0]), .volt_peak_end_i(ev[11][0]),
        .irq_o(irq), .event_interrupt_enable_group_b_o(mask_o));
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One classic cycle; read data lands in q at the ack edge
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 0;
        stb <= 0;
        if (n >= 20) begin
            chk("ack timeout", 1, 0);
            end_sim();
        end
    endtask
    // Extra cycle lets a level-entry detector register its edge
    task automatic pulse(input int g, input int p);
        @(posedge clk_i);
        ev[g] <= 3'h1 << p;
        @(posedge clk_i);
        ev[g] <= 3'h0;
        @(posedge clk_i);
        #1;
    endtask
    task automatic sum(input logic [23:0] a, input logic [23:0] b);
        @(posedge clk_i);
        ps <= a;
        nv <= b;
        sv <= 1;
        @(posedge clk_i);
        sv <= 0;
        @(posedge clk_i);
        #1;
    endtask
    function automatic int sbit(input int g, input int p);
        case (g)
            0, 1, 2: return g;
            3, 4, 5, 6: return 3 * g - 6 + p;
            7, 8, 9: return g + 9;
            default: return g + 13;
        endcase
    endfunction
    function automatic logic [31:0] pexp(input int g, input int p);
        case (g)
            7: return 32'h1 << (12 + p);
            8: return 32'h1 << (3 + p);
            9: return 32'h1 << (9 + p);
            default: return 32'h0;
        endcase
    endfunction
    // Main sequence: reset, table of events, then boundary cases
    initial begin
        foreach (ev[i]) ev[i] = 3'h0;
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        bus(0, `PQIM_OFF_MASK, 0);
        chk("mask reset", 32'h0, q);
        chk("boot irq", 1, irq);
        bus(1, `PQIM_OFF_MASK, 32'hFFFF_FFFF);
        bus(0, `PQIM_OFF_MASK, 0);
        chk("mask rw", 32'h019F_FFFF, q);
        chk("mask out", 32'h019F_FFFF, mask_o);
        bus(1, `PQIM_OFF_STATUS, 32'h0000_8000);
        #1;
        chk("boot clear", 0, irq);
        bus(0, 8'h10, 0);
        chk("unmapped", 32'h0, q);
        foreach (ROWS[i]) begin
            sb = sbit(ROWS[i].g, ROWS[i].p);
            bus(1, `PQIM_OFF_MASK, ROWS[i].e ? 32'h1 << sb : 32'h0);
            pulse(ROWS[i].g, ROWS[i].p);
            chk("irq", ROWS[i].e, irq);
            bus(0, `PQIM_OFF_STATUS, 0);
            chk("status", 32'h1 << sb, q);
            bus(0, `PQIM_OFF_PHASE, 0);
            chk("phase", pexp(ROWS[i].g, ROWS[i].p), q);
            bus(1, `PQIM_OFF_STATUS, 32'hFFFF_FFFF);
            bus(1, `PQIM_OFF_PHASE, 32'hFFFF_FFFF);
            #1;
            chk("irq clear", 0, irq);
        end
        // Phase A then C with no B between
        bus(1, `PQIM_OFF_MASK, 32'h0008_0000);
        pulse(5, 0);
        pulse(5, 2);
        chk("order irq", 1, irq);
        bus(0, `PQIM_OFF_STATUS, 0);
        chk("order status", 32'h0008_0A00, q);
        bus(1, `PQIM_OFF_STATUS, 32'hFFFF_FFFF);
        // Difference equal to the threshold must not trip
        bus(1, `PQIM_OFF_THRESH, 32'h0000_0064);
        bus(1, `PQIM_OFF_MASK, 32'h0010_0000);
        sum(24'h00_0096, 24'h00_0032);
        chk("sum equal", 0, irq);
        sum(24'hFF_FFF6, 24'h00_005B);
        chk("sum over", 1, irq);
        bus(0, `PQIM_OFF_STATUS, 0);
        chk("sum status", 32'h0010_0000, q);
        // Second reset in mid-run
        rst_i <= 1;
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        bus(0, `PQIM_OFF_MASK, 0);
        chk("mask reset 2", 32'h0, q);
        chk("boot irq 2", 1, irq);
        end_sim();
    end
endmodule

bind pqim_top pqim_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .event_interrupt_enable_group_b_o(event_interrupt_enable_group_b_o),
    .dip_i(dip_i), .curr_peak_end_i(curr_peak_end_i),
    .volt_peak_end_i(volt_peak_end_i));

`default_nettype wire
